/* File: pkg/tsb_cfg.svh */
`ifndef TSB_CFG_SVH
`define TSB_CFG_SVH
// Register indices; the byte address on the bus is four times the index
`define TSB_IDX_COUNT 4'h0
`define TSB_IDX_CTRL 4'h1
`define TSB_IDX_PTR_A 4'h2
`define TSB_IDX_PTR_B 4'h4
`define TSB_IDX_BLKLEN 4'h6
`define TSB_IDX_SELECT 4'h8
`define TSB_IDX_DONE 4'h9
`define TSB_IDX_STATUS 4'ha
// Reset values
`define TSB_RST_BYTE 8'h00
`define TSB_RST_WORD 16'h0000
// Server control byte fields
`define TSB_MODE_HI 7
`define TSB_MODE_LO 5
`define TSB_BIT_BYTE 4
`define TSB_BIT_SRC_KEEP 3
`define TSB_BIT_RETAIN 3
`define TSB_BIT_DST_KEEP 2
`define TSB_BIT_SRC_INC 1
`define TSB_BIT_DST_INC 0
// Mode select codes
`define TSB_MODE_BLOCK 3'b000
`define TSB_MODE_SCAN 3'b110
// Status register fields
`define TSB_STAT_BUSY 0
`define TSB_STAT_ERR 1
`define TSB_STAT_LAT_LO 16
// Block length and pointer steps
`define TSB_MAX_BLOCK_LEN 32
`define TSB_STEP_BYTE 16'h0001
`define TSB_STEP_WORD 16'h0002
`endif

/* File: pkg/tsb_pkg.sv */
package tsb_pkg;
  // Sequencer states of the transfer server
  typedef enum logic [2:0] {
    tsb_st_idle = 3'b000,
    tsb_st_blk_rd = 3'b001,
    tsb_st_blk_wr = 3'b010,
    tsb_st_blk_end = 3'b011,
    tsb_st_scn_cmd = 3'b100,
    tsb_st_scn_res = 3'b101,
    tsb_st_scn_wr = 3'b110,
    tsb_st_scn_end = 3'b111
  } tsb_state_type;
endpackage : tsb_pkg

/* File: rtl/tsb_mem_port.sv */
module tsb_mem_port (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic we_i,
  input wire logic byte_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_byte_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i
);
  // Request stays up with stable fields until the memory acknowledges
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_byte_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 16'h0000;
    end else if (mem_req_o) begin
      if (mem_ack_i) begin
        mem_req_o <= 1'b0;
      end
    end else if (start_i) begin
      mem_req_o <= 1'b1;
      mem_we_o <= we_i;
      mem_byte_o <= byte_i;
      mem_addr_o <= addr_i;
      mem_wdata_o <= byte_i ? {8'h00, wdata_i[7:0]} : wdata_i;
    end
  end

  // Completion pulse with captured read data, upper byte cleared for bytes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      done_o <= mem_req_o && mem_ack_i;
      if (mem_req_o && mem_ack_i && !mem_we_o) begin
        rdata_o <= mem_byte_o ? {8'h00, mem_rdata_i[7:0]} : mem_rdata_i;
      end
    end
  end

  property p_req_hold;
    @(posedge core_clk_i) disable iff (srst_i)
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("memory request dropped or changed before ack");

  property p_done_after_ack;
    @(posedge core_clk_i) disable iff (srst_i)
    mem_req_o && mem_ack_i |=> done_o && !mem_req_o;
  endproperty
  a_done_after_ack: assert property (p_done_after_ack)
    else $error("access completion not reported after ack");
endmodule : tsb_mem_port

/* File: rtl/tsb_server.sv */
// Implementation choice: register access over Wishbone.
`include "tsb_cfg.svh"
module tsb_server
  import tsb_pkg::*;
#(
  parameter int MAX_BLOCK_LEN = `TSB_MAX_BLOCK_LEN
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic srv_req_i,
  output logic srv_done_o,
  output logic srv_busy_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_byte_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic [15:0] conv_cmd_o,
  output logic conv_cmd_wr_o
);
  if (MAX_BLOCK_LEN < 1 || MAX_BLOCK_LEN > 255) begin : g_len_check
    $error("MAX_BLOCK_LEN must lie in 1..255");
  end

  localparam logic [7:0] MAX_LEN = 8'(MAX_BLOCK_LEN);

  // Pointer step for one element
  function automatic logic [15:0] elem_step(input logic byte_sel);
    elem_step = byte_sel ? `TSB_STEP_BYTE : `TSB_STEP_WORD;
  endfunction : elem_step

  tsb_state_type state_q;
  logic [7:0] count_q;
  logic [7:0] ctrl_q;
  logic [15:0] ptr_a_q;
  logic [15:0] ptr_b_q;
  logic [7:0] blklen_q;
  logic sel_q;
  logic done_q;
  logic err_q;
  logic pend_q;
  logic acc_q;
  logic [15:0] wa_q;
  logic [15:0] wb_q;
  logic [7:0] left_q;
  logic [15:0] data_q;
  logic [15:0] cmd_q;
  logic [15:0] lat_q;
  logic [15:0] last_lat_q;
  logic [31:0] rd_data;
  logic [3:0] idx;
  logic mapped;
  logic wr_go;
  logic [2:0] mode;
  logic byte_sel;
  logic start;
  logic at_end;
  logic last_cycle;
  logic mem_go;
  logic mem_we;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic mem_byte;
  logic mem_done;
  logic [15:0] mem_rdata;
  logic [7:0] eff_len;

  // Field decode and start condition
  assign mode = ctrl_q[`TSB_MODE_HI:`TSB_MODE_LO];
  assign byte_sel = ctrl_q[`TSB_BIT_BYTE];
  assign start = (state_q == tsb_st_idle) && pend_q && sel_q
    && (count_q != 8'h00);
  assign at_end = (state_q == tsb_st_blk_end)
    || (state_q == tsb_st_scn_end);
  assign last_cycle = at_end && (count_q == 8'h01);
  assign srv_done_o = done_q;
  assign srv_busy_o = (state_q != tsb_st_idle);

  // Block length clamped to what the sequencer serves; zero acts as one
  assign eff_len = (blklen_q == 8'h00) ? 8'h01 :
    (blklen_q > MAX_LEN) ? MAX_LEN : blklen_q;

  // Bus slave decode: one word per register, index in address bits 5:2
  assign idx = wb_adr_i[5:2];
  assign mapped = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[1:0] == 2'b00);
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && mapped;

  // Read multiplexer, unmapped and reserved bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (mapped) begin
      case (idx)
        `TSB_IDX_COUNT: rd_data = {24'h000000, count_q};
        `TSB_IDX_CTRL: rd_data = {24'h000000, ctrl_q};
        `TSB_IDX_PTR_A: rd_data = {16'h0000, ptr_a_q};
        `TSB_IDX_PTR_B: rd_data = {16'h0000, ptr_b_q};
        `TSB_IDX_BLKLEN: rd_data = {24'h000000, blklen_q};
        `TSB_IDX_SELECT: rd_data = {31'h00000000, sel_q};
        `TSB_IDX_DONE: rd_data = {31'h00000000, done_q};
        `TSB_IDX_STATUS: begin
          rd_data[`TSB_STAT_BUSY] = srv_busy_o;
          rd_data[`TSB_STAT_ERR] = err_q;
          rd_data[31:`TSB_STAT_LAT_LO] = last_lat_q;
        end
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // Classic handshake: ack one cycle after the strobe, every access answered
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // Control block fields: software writes while idle, server updates at end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      count_q <= `TSB_RST_BYTE;
      ctrl_q <= `TSB_RST_BYTE;
      ptr_a_q <= `TSB_RST_WORD;
      ptr_b_q <= `TSB_RST_WORD;
      blklen_q <= `TSB_RST_BYTE;
    end else if (state_q == tsb_st_blk_end) begin
      if (ctrl_q[`TSB_BIT_SRC_KEEP]) begin
        ptr_a_q <= wa_q;
      end
      if (ctrl_q[`TSB_BIT_DST_KEEP]) begin
        ptr_b_q <= wb_q;
      end
      count_q <= count_q - 8'h01;
    end else if (state_q == tsb_st_scn_end) begin
      if (ctrl_q[`TSB_BIT_RETAIN]) begin
        ptr_a_q <= wa_q;
      end
      count_q <= count_q - 8'h01;
    end else if (wr_go && state_q == tsb_st_idle) begin
      case (idx)
        `TSB_IDX_COUNT: if (wb_sel_i[0]) count_q <= wb_dat_i[7:0];
        `TSB_IDX_CTRL: if (wb_sel_i[0]) ctrl_q <= wb_dat_i[7:0];
        `TSB_IDX_PTR_A: begin
          if (wb_sel_i[0]) ptr_a_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) ptr_a_q[15:8] <= wb_dat_i[15:8];
        end
        `TSB_IDX_PTR_B: begin
          if (wb_sel_i[0]) ptr_b_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) ptr_b_q[15:8] <= wb_dat_i[15:8];
        end
        `TSB_IDX_BLKLEN: if (wb_sel_i[0]) blklen_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Select bit: set by software, cleared by the server at count zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sel_q <= 1'b0;
    end else if (last_cycle) begin
      sel_q <= 1'b0;
    end else if (wr_go && idx == `TSB_IDX_SELECT && wb_sel_i[0]) begin
      sel_q <= wb_dat_i[0];
    end
  end

  // Done bit: write one to clear, a new completion wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      done_q <= 1'b0;
    end else if (last_cycle) begin
      done_q <= 1'b1;
    end else if (wr_go && idx == `TSB_IDX_DONE && wb_sel_i[0]
                 && wb_dat_i[0]) begin
      done_q <= 1'b0;
    end
  end

  // Pending service request; an arrival during its own take is kept
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pend_q <= 1'b0;
    end else if (srv_req_i) begin
      pend_q <= 1'b1;
    end else if (state_q == tsb_st_idle) begin
      pend_q <= 1'b0;
    end
  end

  // Unsupported mode codes are refused and flagged; write one to clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      err_q <= 1'b0;
    end else if (start && mode != `TSB_MODE_BLOCK
                 && mode != `TSB_MODE_SCAN) begin
      err_q <= 1'b1;
    end else if (wr_go && idx == `TSB_IDX_STATUS && wb_sel_i[0]
                 && wb_dat_i[`TSB_STAT_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // Sequencer: a started service runs to its end with no way out
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= tsb_st_idle;
    end else begin
      case (state_q)
        tsb_st_idle: begin
          if (start && mode == `TSB_MODE_BLOCK) begin
            state_q <= tsb_st_blk_rd;
          end else if (start && mode == `TSB_MODE_SCAN) begin
            state_q <= tsb_st_scn_cmd;
          end
        end
        tsb_st_blk_rd: if (mem_done) state_q <= tsb_st_blk_wr;
        tsb_st_blk_wr: begin
          if (mem_done) begin
            state_q <= (left_q <= 8'h01) ? tsb_st_blk_end
              : tsb_st_blk_rd;
          end
        end
        tsb_st_blk_end: state_q <= tsb_st_idle;
        tsb_st_scn_cmd: if (mem_done) state_q <= tsb_st_scn_res;
        tsb_st_scn_res: if (mem_done) state_q <= tsb_st_scn_wr;
        tsb_st_scn_wr: if (mem_done) state_q <= tsb_st_scn_end;
        tsb_st_scn_end: state_q <= tsb_st_idle;
        default: state_q <= tsb_st_idle;
      endcase
    end
  end

  // One memory access per access state
  assign mem_go = !acc_q && (state_q != tsb_st_idle) && !at_end;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      acc_q <= 1'b0;
    end else if (mem_done) begin
      acc_q <= 1'b0;
    end else if (mem_go) begin
      acc_q <= 1'b1;
    end
  end

  // Access selection per state
  always_comb begin
    mem_we = 1'b0;
    mem_byte = 1'b0;
    mem_addr = wa_q;
    mem_wdata = data_q;
    case (state_q)
      tsb_st_blk_rd: mem_byte = byte_sel;
      tsb_st_blk_wr: begin
        mem_we = 1'b1;
        mem_byte = byte_sel;
        mem_addr = wb_q;
      end
      tsb_st_scn_res: mem_addr = ptr_b_q;
      tsb_st_scn_wr: mem_we = 1'b1;
      default: mem_addr = wa_q;
    endcase
  end

  // Working pointers, element counter and held data
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wa_q <= `TSB_RST_WORD;
      wb_q <= `TSB_RST_WORD;
      left_q <= `TSB_RST_BYTE;
      data_q <= `TSB_RST_WORD;
      cmd_q <= `TSB_RST_WORD;
    end else if (start) begin
      wa_q <= ptr_a_q;
      wb_q <= ptr_b_q;
      left_q <= eff_len;
    end else if (mem_done) begin
      case (state_q)
        tsb_st_blk_rd: data_q <= mem_rdata;
        tsb_st_blk_wr: begin
          if (ctrl_q[`TSB_BIT_SRC_INC]) begin
            wa_q <= wa_q + elem_step(byte_sel);
          end
          if (ctrl_q[`TSB_BIT_DST_INC]) begin
            wb_q <= wb_q + elem_step(byte_sel);
          end
          left_q <= left_q - 8'h01;
        end
        tsb_st_scn_cmd: begin
          cmd_q <= mem_rdata;
          wa_q <= wa_q + `TSB_STEP_WORD;
        end
        tsb_st_scn_res: data_q <= mem_rdata;
        tsb_st_scn_wr: wa_q <= wa_q + `TSB_STEP_WORD;
        default: data_q <= data_q;
      endcase
    end
  end

  // Held command goes to the converter, starting the next conversion
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      conv_cmd_o <= `TSB_RST_WORD;
      conv_cmd_wr_o <= 1'b0;
    end else begin
      conv_cmd_wr_o <= (state_q == tsb_st_scn_end);
      if (state_q == tsb_st_scn_end) begin
        conv_cmd_o <= cmd_q;
      end
    end
  end

  // Length of the last service in clocks, saturating, shows the latency
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      lat_q <= `TSB_RST_WORD;
      last_lat_q <= `TSB_RST_WORD;
    end else if (start) begin
      lat_q <= 16'h0001;
    end else if (srv_busy_o) begin
      if (lat_q != 16'hffff) begin
        lat_q <= lat_q + 16'h0001;
      end
      if (at_end) begin
        last_lat_q <= lat_q;
      end
    end
  end

  tsb_mem_port u_mem_port (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .start_i(mem_go),
    .we_i(mem_we),
    .byte_i(mem_byte),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .done_o(mem_done),
    .rdata_o(mem_rdata),
    .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o),
    .mem_byte_o(mem_byte_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i)
  );

  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_mode_block;
    start && mode == `TSB_MODE_BLOCK |=> state_q == tsb_st_blk_rd;
  endproperty
  a_mode_block: assert property (p_mode_block)
    else $error("block mode not entered");

  property p_mode_scan;
    start && mode == `TSB_MODE_SCAN |=> state_q == tsb_st_scn_cmd;
  endproperty
  a_mode_scan: assert property (p_mode_scan)
    else $error("scan mode not entered");

  property p_mode_other;
    start && mode != `TSB_MODE_BLOCK && mode != `TSB_MODE_SCAN
      |=> state_q == tsb_st_idle && err_q;
  endproperty
  a_mode_other: assert property (p_mode_other)
    else $error("unsupported mode not refused");

  property p_block_whole;
    state_q == tsb_st_blk_wr && mem_done && left_q > 8'h01
      |=> state_q == tsb_st_blk_rd;
  endproperty
  a_block_whole: assert property (p_block_whole)
    else $error("block ended before its last element");

  property p_src_step;
    state_q == tsb_st_blk_wr && mem_done && ctrl_q[`TSB_BIT_SRC_INC]
      |=> wa_q == $past(wa_q) + (byte_sel ? 16'h0001 : 16'h0002);
  endproperty
  a_src_step: assert property (p_src_step)
    else $error("source pointer step wrong");

  property p_dst_hold;
    state_q == tsb_st_blk_wr && mem_done && !ctrl_q[`TSB_BIT_DST_INC]
      |=> $stable(wb_q);
  endproperty
  a_dst_hold: assert property (p_dst_hold)
    else $error("destination moved without autoincrement");

  property p_src_restore;
    state_q == tsb_st_blk_end && !ctrl_q[`TSB_BIT_SRC_KEEP]
      |=> $stable(ptr_a_q);
  endproperty
  a_src_restore: assert property (p_src_restore)
    else $error("source pointer not restored");

  property p_dst_keep;
    state_q == tsb_st_blk_end && ctrl_q[`TSB_BIT_DST_KEEP]
      |=> ptr_b_q == $past(wb_q);
  endproperty
  a_dst_keep: assert property (p_dst_keep)
    else $error("destination pointer not kept");

  property p_count_dec;
    at_end |=> count_q == $past(count_q) - 8'h01;
  endproperty
  a_count_dec: assert property (p_count_dec)
    else $error("cycle count not decremented");

  property p_done_zero;
    last_cycle |=> done_q && !sel_q && state_q == tsb_st_idle;
  endproperty
  a_done_zero: assert property (p_done_zero)
    else $error("count zero did not end service");

  sequence s_cmd_fetched;
    state_q == tsb_st_scn_cmd && mem_done;
  endsequence
  sequence s_result_read;
    state_q == tsb_st_scn_res && mem_req_o && mem_addr_o == ptr_b_q;
  endsequence
  property p_scan_order;
    s_cmd_fetched |=> state_q == tsb_st_scn_res ##[1:2] s_result_read;
  endproperty
  a_scan_order: assert property (p_scan_order)
    else $error("result not fetched from second pointer");

  property p_cmd_out;
    state_q == tsb_st_scn_end
      |=> conv_cmd_wr_o && conv_cmd_o == $past(cmd_q) ##1 !conv_cmd_wr_o;
  endproperty
  a_cmd_out: assert property (p_cmd_out)
    else $error("held command not issued");

  property p_retain;
    state_q == tsb_st_scn_end
      |=> ptr_a_q == (ctrl_q[`TSB_BIT_RETAIN] ? $past(wa_q)
        : $past(ptr_a_q));
  endproperty
  a_retain: assert property (p_retain)
    else $error("table pointer retain wrong");
endmodule : tsb_server

/* File: sim/tsb_mem_model.sv */
module tsb_mem_model (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] dly_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic mem_byte_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [3:0] wait_q;
  logic [7:0] a;
  assign a = mem_addr_i[7:0];
  // Answers after dly_i cycles; read bus toggles whenever not valid
  always @(posedge core_clk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (srst_i) begin
      wait_q <= 4'h0;
      mem_rdata_o <= 16'h5a5a;
    end else if (mem_req_i && !mem_ack_o) begin
      if (wait_q < dly_i) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        mem_ack_o <= 1'b1;
        if (mem_we_i) begin
          mem[a] <= mem_wdata_i[7:0];
          if (!mem_byte_i) mem[a + 8'h01] <= mem_wdata_i[15:8];
        end else if (mem_byte_i) begin
          mem_rdata_o <= {~mem[a], mem[a]}; // Upper lane is junk
        end else begin
          mem_rdata_o <= {mem[a + 8'h01], mem[a]};
        end
      end
    end
  end
endmodule : tsb_mem_model

/* File: sim/tsb_server_tb.sv */
module tsb_server_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic srv_req_i = 1'b0;
  logic srv_done_o, srv_busy_o;
  logic mem_req_o, mem_we_o, mem_byte_o, mem_ack_i;
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, conv_cmd_o;
  logic conv_cmd_wr_o;
  logic [3:0] dly = 4'h0;
  logic [15:0] cmd_seen;
  logic [31:0] x;
  int cmd_n = 0;
  int err_total = 0;
  int checked = 0;

  tsb_server #(.MAX_BLOCK_LEN(32)) i_dut (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(4'hf), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .srv_req_i(srv_req_i), .srv_done_o(srv_done_o),
    .srv_busy_o(srv_busy_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_byte_o(mem_byte_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .conv_cmd_o(conv_cmd_o),
    .conv_cmd_wr_o(conv_cmd_wr_o));

  tsb_mem_model i_mem (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .dly_i(dly), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_byte_i(mem_byte_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));

  // 125 MHz clock
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Captures every command written to the converter
  always @(posedge core_clk_i) begin
    if (conv_cmd_wr_o === 1'b1) begin
      cmd_seen <= conv_cmd_o;
      cmd_n <= cmd_n + 1;
    end
  end

  task automatic complete_run;
    $display("counts: %0d compared, %0d mismatched", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang(input bit hit);
    if (hit) begin
      err_total++;
      $display("mismatch at %0t: wait ran out", $time);
      complete_run();
    end
  endtask : hang

  // One classic Wishbone cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    hang(n >= 20);
    x = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    bus(1'b1, adr, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
    bus(1'b0, adr, 32'h0);
    chk(x, e);
  endtask : rd_chk

  // Raises one service request and waits for the service to finish
  task automatic serve;
    int n;
    n = 0;
    @(posedge core_clk_i);
    srv_req_i <= 1'b1;
    @(posedge core_clk_i);
    srv_req_i <= 1'b0;
    while (srv_busy_o !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      n++;
    end
    hang(n >= 20);
    while (srv_busy_o !== 1'b0 && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    hang(n >= 2000);
    repeat (2) @(posedge core_clk_i);
  endtask : serve

  task automatic setup(input logic [7:0] cnt, input logic [7:0] ctl,
                       input logic [15:0] pa, input logic [15:0] pb);
    wr(8'h00, {24'h0, cnt});
    wr(8'h04, {24'h0, ctl});
    wr(8'h08, {16'h0, pa});
    wr(8'h10, {16'h0, pb});
    wr(8'h20, 32'h1);
  endtask : setup

  // Main sequence
  initial begin
    for (int i = 0; i < 256; i++) i_mem.mem[i] = 8'(i ^ 8'h5c);
    for (int i = 0; i < 16; i++) i_mem.mem[8'h60 + i] = 8'h00;
    repeat (6) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(8'(i * 4), 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0);
    $display("test reset done");
    // Bytes, both pointers step, destination kept, source restored
    setup(8'h03, 8'h17, 16'h0020, 16'h0060);
    wr(8'h18, 32'h5);
    for (int k = 0; k < 3; k++) begin
      serve();
      rd_chk(8'h00, 32'(2 - k));
    end
    for (int i = 0; i < 15; i++)
      chk(i_mem.mem[8'h60 + i], 32'((i % 5) ^ 8'h7c));
    rd_chk(8'h08, 32'h20);
    rd_chk(8'h10, 32'h6f);
    rd_chk(8'h20, 32'h0);
    chk(srv_done_o, 1'b1);
    wr(8'h24, 32'h1);
    chk(srv_done_o, 1'b0);
    $display("test block bytes done");
    // Words, slow memory, both pointers kept
    dly <= 4'h3;
    setup(8'h01, 8'h0f, 16'h0030, 16'h0080);
    wr(8'h18, 32'h2);
    serve();
    for (int i = 0; i < 4; i++)
      chk(i_mem.mem[8'h80 + i], 32'((i + 8'h30) ^ 8'h5c));
    rd_chk(8'h08, 32'h34);
    rd_chk(8'h10, 32'h84);
    chk(srv_done_o, 1'b1);
    wr(8'h24, 32'h1);
    chk(srv_done_o, 1'b0);
    $display("test block words done");
    // Converter scan, pointer restored then retained
    for (int r = 0; r < 2; r++) begin
      // The retaining run issues the closing zero command
      i_mem.mem[8'h90] = r ? 8'h00 : 8'h34;
      i_mem.mem[8'h91] = r ? 8'h00 : 8'h12;
      i_mem.mem[8'hc0] = 8'(8'hc0 + r);
      i_mem.mem[8'hc1] = 8'hab;
      setup(8'h01, r ? 8'hca : 8'hc2, 16'h0090, 16'h00c0);
      serve();
      chk(cmd_n, 32'(r + 1));
      chk(cmd_seen, r ? 16'h0000 : 16'h1234);
      x = {16'h0000, i_mem.mem[8'h93], i_mem.mem[8'h92]};
      chk(x, 32'habc0 + 32'(r));
      chk(x >> 6, 32'h2af);
      rd_chk(8'h08, r ? 32'h94 : 32'h90);
      rd_chk(8'h00, 32'h0);
      chk(srv_done_o, 1'b1);
      wr(8'h24, 32'h1);
    end
    $display("test scan done");
    // Reserved mode code is refused
    setup(8'h01, 8'h20, 16'h0020, 16'h0060);
    @(posedge core_clk_i);
    srv_req_i <= 1'b1;
    @(posedge core_clk_i);
    srv_req_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    chk(srv_busy_o, 1'b0);
    bus(1'b0, 8'h28, 32'h0);
    chk(x[1:0], 2'b10);
    chk(x[31:16], 16'h0016);
    rd_chk(8'h00, 32'h1);
    $display("test refused mode done");
    // Error flag clears on a written one, then a reset while idle
    wr(8'h28, 32'h2);
    rd_chk(8'h28, 32'h0016_0000);
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd_chk(8'h28, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h20, 32'h0);
    $display("test reset again done");
    complete_run();
  end
endmodule : tsb_server_tb
